// File: hdl/clock_mode_control.sv
// Clock and operating-mode control for a disc decoder, with AHB-Lite slave.
// Assumes the core supplies audio, motor and servo signals on hclk; the
// crystal choice is a board strap and the off-track pin is asynchronous.
//
// Notes on behaviour
// - Only single and double disc speed exist.
// - Top two speed bits choose speed and crystal division.
// - MCU clock is 5.6448 MHz on 16.9344 MHz without multiplier.
// - MCU clock reaches its pin only after shadow enable is set.
// - Lock-to-disc bypasses the FIFO and scales audio clocks to disc.
// - Disc speed tracked only between quarter and full nominal.
// - A configuration register bit switches lock-to-disc.
// - Two standby modes from speed register; core keeps running.
// - Stop standby switches off most inputs and outputs.
// - Pause standby kills audio, keeps motor and subcode running.
// - Motor pins float in stop standby and reset, run in pause.
// - Audio pins tri-state in both standby modes.
// - Bus, crystal, system clock, versatile, flag pins unaffected.
// - Slicer samples x1, or x4/x8 with multiplier and field top bit low.
// - Bit loop steers slice current into external capacitor.
// - Bit loop internal; bandwidth and equalization from two registers.
// - Off-track from servo with polarity, or from versatile input.
// - Off-track high marks all incoming channel data bad.
// - MCU clock pin shows 11.2896, 5.6448 or 4.2336 MHz.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module clock_mode_control #(
  parameter int loop_width = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] crystal_select,
  input wire logic multiplier_enable_pin,
  input wire logic versatile_in_a,
  input wire logic servo_offtrack,
  input wire logic focus_polarity_param,
  input wire logic slice_up,
  input wire logic slice_down,
  input wire logic disc_rate_ok,
  input wire logic disc_rate_low,
  input wire logic hf_data_err_in,
  input wire clock_mode_pkg::audio_pins_type audio_in,
  input wire clock_mode_pkg::motor_pins_type motor_in,
  output clock_mode_pkg::audio_pins_type audio_out,
  output clock_mode_pkg::audio_pins_type audio_oe,
  output clock_mode_pkg::motor_pins_type motor_out,
  output clock_mode_pkg::motor_pins_type motor_oe,
  output logic mcu_clock_out,
  output logic mcu_clock_oe,
  output logic double_speed,
  output logic [1:0] crystal_div_sel,
  output logic [3:0] slicer_rate,
  output logic slice_src_q_up,
  output logic slice_src_q_down,
  output logic [loop_width-1:0] loop_bandwidth,
  output logic [loop_width-1:0] loop_equalization,
  output logic fifo_bypass,
  output logic audio_rate_follow,
  output logic hf_data_err_out,
  output logic subcode_enable,
  output logic stop_standby,
  output logic hot_pause_standby
);
  // Loop settings each sit in a small field of their own bus word, so keep them narrow
  if (loop_width < 1 || loop_width > 8)
  begin : g_width_check
    $error("loop_width must be 1 to 8");
  end

  logic [3:0] speed_q;
  logic [3:0] slicer_cfg_q;
  logic [loop_width-1:0] bw_q;
  logic [loop_width-1:0] eq_q;
  logic offtrack_sel_q;
  logic lock_q;
  logic shadow_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_pend_q;
  logic [7:0] rd_addr_q;
  localparam int sync_len = clock_mode_pkg::sync_stages;
  logic [sync_len-1:0] v1_sync_q;
  logic v1_level_q;
  logic [1:0] div_q;
  logic mcu_clk_q;
  logic [1:0] standby;
  logic [1:0] mcu_sel;
  logic offtrack;
  logic take;

  // Address phase capture; every transfer answers OKAY with no wait state
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take)
      begin
        wr_addr_q <= haddr;
        rd_addr_q <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Register writes take effect at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      speed_q <= clock_mode_pkg::speed_rst;
      slicer_cfg_q <= clock_mode_pkg::slicer_rst;
      bw_q <= '0;
      eq_q <= '0;
      offtrack_sel_q <= 1'b0;
      lock_q <= 1'b0;
      shadow_q <= 1'b0;
    end
    else if (wr_pend_q)
    begin
      unique case (wr_addr_q)
        clock_mode_pkg::speed_off: speed_q <= hwdata[3:0];
        clock_mode_pkg::slicer_off: slicer_cfg_q <= hwdata[3:0];
        clock_mode_pkg::loop_bw_off: bw_q <= hwdata[loop_width-1:0];
        clock_mode_pkg::loop_eq_off: eq_q <= hwdata[loop_width-1:0];
        clock_mode_pkg::offtrack_off: offtrack_sel_q <= hwdata[0];
        clock_mode_pkg::lock_off: lock_q <= hwdata[0];
        clock_mode_pkg::shadow_off: shadow_q <= hwdata[0];
        default: ;
      endcase
    end
  end

  // Reads return the word in the data phase; unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
    begin
      unique case (haddr)
        clock_mode_pkg::speed_off: hrdata <= {28'h0, speed_q};
        clock_mode_pkg::slicer_off: hrdata <= {28'h0, slicer_cfg_q};
        clock_mode_pkg::loop_bw_off: hrdata <= 32'(bw_q);
        clock_mode_pkg::loop_eq_off: hrdata <= 32'(eq_q);
        clock_mode_pkg::offtrack_off: hrdata <= {31'h0, offtrack_sel_q};
        clock_mode_pkg::lock_off: hrdata <= {31'h0, lock_q};
        clock_mode_pkg::shadow_off: hrdata <= {31'h0, shadow_q};
        clock_mode_pkg::status_off:
          hrdata <= {26'h0, hot_pause_standby, stop_standby,
                     hf_data_err_out, audio_rate_follow, double_speed,
                     v1_level_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Low speed bits: 01 stop standby, 10 pause standby, others run
  always_comb
  begin
    unique case (speed_q[1:0])
      2'h1: standby = clock_mode_pkg::standby_stop;
      2'h2: standby = clock_mode_pkg::standby_pause;
      default: standby = clock_mode_pkg::standby_none;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stop_standby <= 1'b0;
      hot_pause_standby <= 1'b0;
      subcode_enable <= 1'b1;
    end
    else
    begin
      stop_standby <= standby == clock_mode_pkg::standby_stop;
      hot_pause_standby <= standby == clock_mode_pkg::standby_pause;
      subcode_enable <= standby != clock_mode_pkg::standby_stop;
    end
  end

  // Speed and division come only from the upper two bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      double_speed <= 1'b0;
      crystal_div_sel <= 2'h0;
    end
    else
    begin
      double_speed <= speed_q[clock_mode_pkg::speed_hi_pos];
      crystal_div_sel <= speed_q[3:2];
    end
  end

  // Slicer rate: the multiplier only helps on 16.9344 or 8.4672 MHz sources
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slicer_rate <= 4'(clock_mode_pkg::slice_x1);
    else if (multiplier_enable_pin && !slicer_cfg_q[3])
    begin
      if (crystal_select == clock_mode_pkg::xtal_16m)
        slicer_rate <= 4'(clock_mode_pkg::slice_x4);
      else if (crystal_select == clock_mode_pkg::xtal_8m)
        slicer_rate <= clock_mode_pkg::slice_x8;
      else
        slicer_rate <= 4'(clock_mode_pkg::slice_x1);
    end
    else
      slicer_rate <= 4'(clock_mode_pkg::slice_x1);
  end

  // Slice level current source, never up and down together
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slice_src_q_up <= 1'b0;
      slice_src_q_down <= 1'b0;
    end
    else
    begin
      slice_src_q_up <= slice_up && !slice_down;
      slice_src_q_down <= slice_down && !slice_up;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      loop_bandwidth <= '0;
      loop_equalization <= '0;
    end
    else
    begin
      loop_bandwidth <= bw_q;
      loop_equalization <= eq_q;
    end
  end

  // Lock-to-disc follows the disc only inside the 25 to 100 percent band
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fifo_bypass <= 1'b0;
      audio_rate_follow <= 1'b0;
    end
    else
    begin
      fifo_bypass <= lock_q;
      audio_rate_follow <= lock_q && disc_rate_ok && !disc_rate_low;
    end
  end

  // Versatile input is asynchronous: three stages, last two must agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      v1_sync_q <= '0;
      v1_level_q <= 1'b0;
    end
    else
    begin
      v1_sync_q <= {v1_sync_q[sync_len-2:0], versatile_in_a};
      if (v1_sync_q[sync_len-1] == v1_sync_q[sync_len-2])
        v1_level_q <= v1_sync_q[sync_len-1];
    end
  end

  assign offtrack = offtrack_sel_q ? v1_level_q
                  : (servo_offtrack ^ focus_polarity_param);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hf_data_err_out <= 1'b0;
    else
      hf_data_err_out <= hf_data_err_in || offtrack;
  end

  // MCU clock rate selection
  always_comb
  begin
    if (crystal_select == clock_mode_pkg::xtal_16m && !multiplier_enable_pin)
      mcu_sel = clock_mode_pkg::mcu_sel_5m6;
    else if (slicer_cfg_q[0])
      mcu_sel = clock_mode_pkg::mcu_sel_4m2;
    else
      mcu_sel = clock_mode_pkg::mcu_sel_11m;
  end

  // Toggle divider stands in for the crystal-derived clock on this model
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 2'h0;
      mcu_clk_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      if (mcu_sel == clock_mode_pkg::mcu_sel_11m || div_q == 2'h3)
        mcu_clk_q <= !mcu_clk_q;
    end
  end

  // Clock, versatile and flag pins ignore standby entirely
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mcu_clock_out <= 1'b0;
      mcu_clock_oe <= 1'b0;
    end
    else
    begin
      mcu_clock_out <= shadow_q && mcu_clk_q;
      mcu_clock_oe <= shadow_q;
    end
  end

  // Motor pins float in stop standby and under reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      motor_out <= '0;
      motor_oe <= '0;
    end
    else
    begin
      motor_out <= motor_in;
      motor_oe <= stop_standby ? 2'b00 : 2'b11;
    end
  end

  // Audio pins float in either standby
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      audio_out <= '0;
      audio_oe <= '1;
    end
    else
    begin
      audio_out <= audio_in;
      audio_oe <= (stop_standby || hot_pause_standby) ? '0 : '1;
    end
  end

  AST_STOP_MOTOR: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_standby |-> ##1 motor_oe == 2'b00)
    else $error("motor pins driven in stop standby");

  AST_PAUSE_MOTOR: assert property (@(posedge hclk) disable iff (!hresetn)
    hot_pause_standby |-> ##1 motor_oe == 2'b11)
    else $error("motor pins off in pause standby");

  sequence standby_seen;
    stop_standby || hot_pause_standby;
  endsequence

  AST_AUDIO_FLOAT: assert property (@(posedge hclk) disable iff (!hresetn)
    standby_seen |-> ##1 audio_oe == '0)
    else $error("audio pins driven in standby");

  AST_STANDBY_MAP: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(speed_q) && speed_q[1:0] == 2'h1 |-> ##1 stop_standby)
    else $error("stop standby not entered");

  AST_SPEED_HI: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 double_speed == $past(speed_q[3]))
    else $error("speed does not follow upper bit");

  AST_MCU_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    !shadow_q |-> ##1 !mcu_clock_out && !mcu_clock_oe)
    else $error("mcu clock out before enable");

  AST_OFFTRACK: assert property (@(posedge hclk) disable iff (!hresetn)
    offtrack |-> ##1 hf_data_err_out)
    else $error("off-track data not flagged");

  AST_LOCK_BAND: assert property (@(posedge hclk) disable iff (!hresetn)
    disc_rate_low |-> ##1 !audio_rate_follow)
    else $error("followed disc outside band");

  AST_SLICE_X8: assert property (@(posedge hclk) disable iff (!hresetn)
    multiplier_enable_pin && !slicer_cfg_q[3]
      && crystal_select == clock_mode_pkg::xtal_8m
      |-> ##1 slicer_rate == clock_mode_pkg::slice_x8)
    else $error("slicer not at eight times");

  AST_LOCK_BYPASS: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_q |-> ##1 fifo_bypass)
    else $error("fifo not bypassed in lock mode");
endmodule : clock_mode_control
`default_nettype wire

// File: hdl/clock_mode_pkg.sv
// Package for the disc decoder clock and mode control block.
// Assumes a single 200 MHz bus clock; constants for the top module and bench, loop_rst and speed_div_pos unused.
package clock_mode_pkg;
  localparam logic [7:0] speed_off = 8'h00;
  localparam logic [7:0] slicer_off = 8'h04;
  localparam logic [7:0] loop_bw_off = 8'h08;
  localparam logic [7:0] loop_eq_off = 8'h0c;
  localparam logic [7:0] offtrack_off = 8'h10;
  localparam logic [7:0] lock_off = 8'h14;
  localparam logic [7:0] shadow_off = 8'h18;
  localparam logic [7:0] status_off = 8'h1c;
  localparam logic [3:0] speed_rst = 4'h0;
  localparam logic [3:0] slicer_rst = 4'h8;
  localparam logic [3:0] loop_rst = 4'h0;
  localparam int speed_hi_pos = 3;
  localparam int speed_div_pos = 2;
  localparam logic [1:0] standby_none = 2'h0;
  localparam logic [1:0] standby_stop = 2'h1;
  localparam logic [1:0] standby_pause = 2'h2;
  localparam logic [1:0] xtal_33m = 2'h0;
  localparam logic [1:0] xtal_16m = 2'h1;
  localparam logic [1:0] xtal_8m = 2'h2;
  localparam logic [2:0] slice_x1 = 3'h1;
  localparam logic [2:0] slice_x4 = 3'h4;
  localparam logic [3:0] slice_x8 = 4'h8;
  localparam logic [1:0] mcu_sel_11m = 2'h0;
  localparam logic [1:0] mcu_sel_5m6 = 2'h1;
  localparam logic [1:0] mcu_sel_4m2 = 2'h2;
  localparam int sync_stages = 3;

  typedef struct packed {
    logic bit_clk;
    logic word_clk;
    logic data;
    logic c2_err;
    logic biphase;
  } audio_pins_type;

  typedef struct packed {
    logic a;
    logic b;
  } motor_pins_type;
endpackage : clock_mode_pkg

// File: tb/disc_core_model.sv
// Model of the disc core and board straps around the control block.
// Assumes the bench requests straps; audio and slice pins move every cycle, motor pins every 32.
`timescale 1ns/1ps
`default_nettype none
module disc_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] xtal_req,
  input wire logic mult_req,
  output logic [1:0] crystal_select,
  output logic multiplier_enable_pin,
  output clock_mode_pkg::audio_pins_type audio_in,
  output clock_mode_pkg::motor_pins_type motor_in,
  output logic hf_data_err_in,
  output logic slice_up,
  output logic slice_down
);
  logic [7:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end
  // Pins keep moving so a stuck enable path cannot hide behind a constant
  assign audio_in = cnt_q[4:0];
  assign motor_in = cnt_q[6:5];
  assign slice_up = cnt_q[0];
  assign slice_down = ~cnt_q[0];
  assign hf_data_err_in = 1'b0;
  assign crystal_select = xtal_req;
  // Board never enables the multiplier with the fast crystal
  assign multiplier_enable_pin = mult_req &&
    (xtal_req != clock_mode_pkg::xtal_33m);
endmodule : disc_core_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the clock and mode control block.
// Assumes an AHB-Lite single slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] xtal_req = 2'h0;
  logic mult_req = 1'b0;
  logic v1 = 1'b0;
  logic servo = 1'b0;
  logic focus = 1'b0;
  logic rate_ok = 1'b0;
  logic rate_low = 1'b0;
  logic rd_dp = 1'b0;
  logic probe = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] crystal_select;
  logic mult_pin;
  logic hf_in;
  logic slice_up;
  logic slice_down;
  clock_mode_pkg::audio_pins_type audio_in;
  clock_mode_pkg::audio_pins_type audio_oe;
  clock_mode_pkg::motor_pins_type motor_in;
  clock_mode_pkg::motor_pins_type motor_oe;
  logic mcu_clock_oe;
  logic double_speed;
  logic [3:0] slicer_rate;
  logic [3:0] loop_bw;
  logic [3:0] loop_eq;
  logic fifo_bypass;
  logic follow;
  logic hf_err;
  logic subcode_enable;
  logic stop_standby;
  logic hot_pause_standby;
  logic hresp;
  logic [1:0] div_sel;
  logic src_up;
  logic src_dn;
  logic mcu_clock_out;
  logic mco_q = 1'b0;
  clock_mode_pkg::audio_pins_type audio_out;
  int tog = 0;
  int base = 0;
  logic [35:0] exp_q[$];
  logic [35:0] nx;
  logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'ha};
  logic [3:0] c;
  logic [31:0] r;
  int errors = 0;
  int n_compared = 0;
  int seed = 26172;
  int cyc = 0;

  always #2.5 hclk = ~hclk;

  disc_core_model partner (.hclk(hclk), .hresetn(hresetn),
    .xtal_req(xtal_req), .mult_req(mult_req),
    .crystal_select(crystal_select), .multiplier_enable_pin(mult_pin),
    .audio_in(audio_in), .motor_in(motor_in), .hf_data_err_in(hf_in),
    .slice_up(slice_up), .slice_down(slice_down));

  clock_mode_control #(.loop_width(4)) DUT (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .crystal_select(crystal_select), .multiplier_enable_pin(mult_pin),
    .versatile_in_a(v1), .servo_offtrack(servo),
    .focus_polarity_param(focus), .slice_up(slice_up),
    .slice_down(slice_down), .disc_rate_ok(rate_ok),
    .disc_rate_low(rate_low), .hf_data_err_in(hf_in),
    .audio_in(audio_in), .motor_in(motor_in), .audio_out(audio_out),
    .audio_oe(audio_oe), .motor_out(), .motor_oe(motor_oe),
    .mcu_clock_out(mcu_clock_out), .mcu_clock_oe(mcu_clock_oe),
    .double_speed(double_speed), .crystal_div_sel(div_sel),
    .slicer_rate(slicer_rate), .slice_src_q_up(src_up),
    .slice_src_q_down(src_dn),
    .loop_bandwidth(loop_bw), .loop_equalization(loop_eq),
    .fifo_bypass(fifo_bypass), .audio_rate_follow(follow),
    .hf_data_err_out(hf_err), .subcode_enable(subcode_enable),
    .stop_standby(stop_standby), .hot_pause_standby(hot_pause_standby));

  function automatic logic [31:0] obs(input logic [3:0] k);
    case (k)
      4'h1: obs = {27'h0, audio_oe};
      4'h2: obs = {30'h0, motor_oe};
      4'h3: obs = {31'h0, double_speed};
      4'h4: obs = {28'h0, slicer_rate};
      4'h5: obs = {31'h0, hf_err};
      4'h6: obs = {30'h0, fifo_bypass, follow};
      4'h7: obs = {31'h0, mcu_clock_oe};
      4'h8: obs = {30'h0, stop_standby, hot_pause_standby};
      4'h9: obs = {28'h0, loop_bw};
      4'hb: obs = {30'h0, src_up ^ slice_up, src_dn ^ slice_down};
      4'hc: obs = {31'h0, subcode_enable};
      4'hd: obs = 32'(tog - base);
      4'he: obs = {30'h0, div_sel};
      4'hf: obs = {26'h0, hresp, 5'(audio_in - audio_out)};
      default: obs = {28'h0, loop_eq};
    endcase
  endfunction : obs

  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e)
    begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, e);
    end
  endtask : check

  task automatic stop_test;
    $display("TB: errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Single transfer; address phase held until hready, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({4'h0, e});
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    settle();
  endtask : wr

  // Probe high one cycle, then low one, so back-to-back calls give separate pulses
  task automatic chk(input logic [3:0] k, input logic [31:0] e);
    exp_q.push_back({k, e});
    probe <= 1'b1;
    @(posedge hclk);
    probe <= 1'b0;
    @(posedge hclk);
  endtask : chk

  // Changes of the mcu clock pin over sixteen edges: fast rate gives 16
  task automatic win(input logic [31:0] e);
    base = tog;
    repeat (15) @(posedge hclk);
    chk(4'hd, e);
  endtask : win

  always @(posedge hclk)
  begin
    mco_q <= mcu_clock_out;
    tog <= tog + ((mcu_clock_out !== mco_q) ? 1 : 0);
  end

  always @(posedge hclk)
  begin
    if (rd_dp || probe)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        nx = exp_q.pop_front();
        check(rd_dp ? hrdata : obs(nx[35:32]), nx[31:0]);
      end
    end
  end

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge hclk);
    chk(4'h2, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(4'h1, 32'h1f);
    chk(4'h2, 32'h3);
    chk(4'h4, 32'h1);
    chk(4'h7, 32'h0);
    chk(4'hb, 32'h3);
    chk(4'hf, 32'h1);
    rd(clock_mode_pkg::slicer_off, 32'h8);
    rd(8'h20, 32'h0);
    wr(clock_mode_pkg::shadow_off, 32'h1);
    chk(4'h7, 32'h1);
    win(32'd16);
    for (int i = 0; i < 6; i++)
    begin
      c = codes[i];
      wr(clock_mode_pkg::speed_off, {28'h0, c});
      chk(4'h3, {31'h0, c[3]});
      chk(4'h8, {30'h0, c[1:0] == 2'h1, c[1:0] == 2'h2});
      chk(4'h1, (c[1:0] == 2'h0) ? 32'h1f : 32'h0);
      chk(4'h2, (c[1:0] == 2'h1) ? 32'h0 : 32'h3);
      chk(4'h7, 32'h1);
      chk(4'hc, {31'h0, c[1:0] != 2'h1});
      chk(4'he, {30'h0, c[3:2]});
      rd(clock_mode_pkg::speed_off, {28'h0, c});
    end
    rd(clock_mode_pkg::status_off, 32'h22);
    wr(clock_mode_pkg::speed_off, 32'h0);
    wr(clock_mode_pkg::slicer_off, 32'h0);
    xtal_req <= clock_mode_pkg::xtal_16m;
    mult_req <= 1'b1;
    settle();
    chk(4'h4, 32'h4);
    xtal_req <= clock_mode_pkg::xtal_8m;
    settle();
    chk(4'h4, 32'h8);
    mult_req <= 1'b0;
    settle();
    chk(4'h4, 32'h1);
    xtal_req <= clock_mode_pkg::xtal_16m;
    settle();
    win(32'd4);
    mult_req <= 1'b1;
    wr(clock_mode_pkg::slicer_off, 32'h8);
    chk(4'h4, 32'h1);
    rate_ok <= 1'b1;
    wr(clock_mode_pkg::lock_off, 32'h1);
    chk(4'h6, 32'h3);
    rate_ok <= 1'b0;
    settle();
    chk(4'h6, 32'h2);
    rate_ok <= 1'b1;
    rate_low <= 1'b1;
    settle();
    chk(4'h6, 32'h2);
    rate_ok <= 1'b0;
    rate_low <= 1'b0;
    wr(clock_mode_pkg::lock_off, 32'h0);
    chk(4'h6, 32'h0);
    servo <= 1'b1;
    settle();
    chk(4'h5, 32'h1);
    servo <= 1'b0;
    focus <= 1'b1;
    settle();
    chk(4'h5, 32'h1);
    focus <= 1'b0;
    wr(clock_mode_pkg::offtrack_off, 32'h1);
    v1 <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(4'h5, 32'h1);
    v1 <= 1'b0;
    servo <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(4'h5, 32'h0);
    servo <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      wr(clock_mode_pkg::loop_bw_off, r);
      chk(4'h9, {28'h0, r[3:0]});
      wr(clock_mode_pkg::loop_eq_off, ~r);
      chk(4'ha, {28'h0, ~r[3:0]});
    end
    wr(clock_mode_pkg::slicer_off, 32'h1);
    win(32'd4);
    // Pause standby, then a reset in mid-run: motor floats, audio comes back
    wr(clock_mode_pkg::speed_off, 32'h2);
    hresetn <= 1'b0;
    chk(4'h2, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(4'h1, 32'h1f);
    chk(4'h2, 32'h3);
    rd(clock_mode_pkg::speed_off, 32'h0);
    repeat (4) @(posedge hclk);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
